// ---- dpcs_ctrl_stat.sv ----
// debug port control/status register with avalon-mm slave
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dpcs_params.svh"
module dpcs_ctrl_stat (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        clk_en_i,
    // avalon-mm slave
    input  wire logic [3:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    output logic [31:0]      readdata_o,
    output logic             waitrequest_o,
    // power and reset handshakes
    input  wire logic        system_power_ack_i,
    input  wire logic        debug_power_ack_i,
    input  wire logic        debug_reset_ack_i,
    output logic             system_power_req_o,
    output logic             debug_power_req_o,
    output logic             debug_reset_req_o,
    // transaction events from the link and access-port side
    input  wire logic        write_data_error_i,
    input  wire logic        read_done_i,
    input  wire logic        read_ok_i,
    input  wire logic        ap_error_i,
    input  wire logic        overrun_i,
    input  wire logic        push_valid_i,
    input  wire logic        transaction_done_i,
    input  wire logic [31:0] push_write_data_i,
    input  wire logic [31:0] push_target_data_i,
    // configuration seen by the rest of the port
    output dpcs_pkg::dpcs_mode_e transfer_mode_o,
    output logic [3:0]       compare_lane_mask_o,
    output logic             overrun_detect_enable_o
);
    import dpcs_pkg::*;

    dpcs_state_s cur;
    dpcs_state_s nxt;
    logic [3:0]  lane_eq;
    logic        lane_match;
    logic        push_active;
    logic        wr_cs;
    logic        wr_abt;
    logic [31:0] cs_value;

    // per-lane compare; mask bit n covers bits 8n+7:8n
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign lane_eq[g] = ~cur.compare_lane_mask[g] |
                (push_write_data_i[8*g+7:8*g] == push_target_data_i[8*g+7:8*g]);
        end
    endgenerate
    assign lane_match  = &lane_eq;
    assign push_active = push_valid_i &&
        (cur.transfer_mode == DPCS_MODE_VERIFY || cur.transfer_mode == DPCS_MODE_COMPARE);

    // access takes effect on the cycle waitrequest is low
    assign waitrequest_o = (read_i || write_i) && cur.bus_state == DPCS_BUS_IDLE;
    assign wr_cs  = write_i && !waitrequest_o && address_i == `DPCS_OFF_CTRL_STAT;
    assign wr_abt = write_i && !waitrequest_o && address_i == `DPCS_OFF_ABORT;

    always_comb begin
        cs_value = 32'h0000_0000;
        cs_value[`DPCS_BIT_SYS_ACK] = cur.sys_ack_sync[1];
        cs_value[`DPCS_BIT_SYS_REQ] = cur.system_power_req;
        cs_value[`DPCS_BIT_DBG_ACK] = cur.dbg_ack_sync[1];
        cs_value[`DPCS_BIT_DBG_REQ] = cur.debug_power_req;
        cs_value[`DPCS_BIT_RST_ACK] = cur.rst_ack_sync[1];
        cs_value[`DPCS_BIT_RST_REQ] = cur.debug_reset_req;
        cs_value[`DPCS_CNT_HI:`DPCS_CNT_LO] = cur.transaction_count;
        cs_value[`DPCS_MASK_HI:`DPCS_MASK_LO] = cur.compare_lane_mask;
        cs_value[`DPCS_BIT_WDERR] = cur.scan_chain_debug_port ? 1'h0 : cur.write_data_error_flag;
        cs_value[`DPCS_BIT_RDOK] = cur.scan_chain_debug_port ? 1'h0 : cur.read_success_flag;
        cs_value[`DPCS_BIT_STKERR] = cur.sticky_error_flag;
        cs_value[`DPCS_BIT_STKCMP] = cur.sticky_compare_flag;
        cs_value[`DPCS_MODE_HI:`DPCS_MODE_LO] = cur.transfer_mode;
        cs_value[`DPCS_BIT_ORUN] = cur.sticky_overrun_flag;
        cs_value[`DPCS_BIT_ORUN_EN] = cur.overrun_detect_enable;
    end

    always_comb begin
        nxt = cur;
        // two-stage synchronisers for acknowledge pins
        nxt.sys_ack_sync = {cur.sys_ack_sync[0], system_power_ack_i};
        nxt.dbg_ack_sync = {cur.dbg_ack_sync[0], debug_power_ack_i};
        nxt.rst_ack_sync = {cur.rst_ack_sync[0], debug_reset_ack_i};
        // bus: one wait cycle, then the access completes
        if ((read_i || write_i) && cur.bus_state == DPCS_BUS_IDLE) begin
            nxt.bus_state = DPCS_BUS_DONE;
        end else begin
            nxt.bus_state = DPCS_BUS_IDLE;
        end
        // load in the wait cycle so data already stand when waitrequest drops
        if (read_i && cur.bus_state == DPCS_BUS_IDLE) begin
            case (address_i)
                `DPCS_OFF_CTRL_STAT: nxt.readdata = cs_value;
                `DPCS_OFF_CONFIG: nxt.readdata = {30'h0, cur.minimal_port_config, cur.scan_chain_debug_port};
                default: nxt.readdata = 32'h0000_0000;
            endcase
        end
        if (transaction_done_i) begin
            nxt.transaction_count = cur.transaction_count + 12'h001;
        end
        // clears first, so a same-cycle event below wins
        if (wr_cs) begin
            nxt.system_power_req = writedata_i[`DPCS_BIT_SYS_REQ];
            nxt.debug_power_req  = writedata_i[`DPCS_BIT_DBG_REQ];
            nxt.debug_reset_req  = writedata_i[`DPCS_BIT_RST_REQ];
            nxt.overrun_detect_enable = writedata_i[`DPCS_BIT_ORUN_EN];
            // minimal config drops count, mask and mode; zero-only writes assumed
            if (!cur.minimal_port_config) begin
                nxt.transaction_count = writedata_i[`DPCS_CNT_HI:`DPCS_CNT_LO];
                nxt.compare_lane_mask = writedata_i[`DPCS_MASK_HI:`DPCS_MASK_LO];
                nxt.transfer_mode = dpcs_mode_e'(writedata_i[`DPCS_MODE_HI:`DPCS_MODE_LO]);
            end
            if (cur.scan_chain_debug_port) begin
                if (writedata_i[`DPCS_BIT_STKERR]) nxt.sticky_error_flag = 1'h0;
                if (writedata_i[`DPCS_BIT_STKCMP]) nxt.sticky_compare_flag = 1'h0;
                if (writedata_i[`DPCS_BIT_ORUN]) nxt.sticky_overrun_flag = 1'h0;
            end
        end
        if (wr_abt) begin
            if (writedata_i[`DPCS_ABT_WDERR_CLR]) nxt.write_data_error_flag = 1'h0;
            if (writedata_i[`DPCS_ABT_STKERR_CLR]) nxt.sticky_error_flag = 1'h0;
            if (writedata_i[`DPCS_ABT_STKCMP_CLR]) nxt.sticky_compare_flag = 1'h0;
            if (writedata_i[`DPCS_ABT_ORUN_CLR]) nxt.sticky_overrun_flag = 1'h0;
        end
        if (write_i && !waitrequest_o && address_i == `DPCS_OFF_CONFIG) begin
            nxt.scan_chain_debug_port = writedata_i[`DPCS_CFG_SCAN];
            nxt.minimal_port_config = writedata_i[`DPCS_CFG_MIN];
        end
        // hardware events
        if (write_data_error_i) nxt.write_data_error_flag = 1'h1;
        if (read_done_i) nxt.read_success_flag = read_ok_i;
        if (ap_error_i) nxt.sticky_error_flag = 1'h1;
        if (overrun_i && cur.overrun_detect_enable) nxt.sticky_overrun_flag = 1'h1;
        if (push_active && !cur.minimal_port_config &&
            ((cur.transfer_mode == DPCS_MODE_COMPARE && !lane_match) ||
             (cur.transfer_mode == DPCS_MODE_VERIFY && lane_match))) begin
            nxt.sticky_compare_flag = 1'h1;
        end
    end

    // count, mask and mode have no reset: their powerup value is unknown
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cur.sys_ack_sync          <= 2'h0;
            cur.dbg_ack_sync          <= 2'h0;
            cur.rst_ack_sync          <= 2'h0;
            cur.system_power_req      <= `DPCS_RST_FLAG;
            cur.debug_power_req       <= `DPCS_RST_FLAG;
            cur.debug_reset_req       <= `DPCS_RST_FLAG;
            cur.write_data_error_flag <= `DPCS_RST_FLAG;
            cur.read_success_flag     <= `DPCS_RST_FLAG;
            cur.sticky_error_flag     <= `DPCS_RST_FLAG;
            cur.sticky_compare_flag   <= `DPCS_RST_FLAG;
            cur.sticky_overrun_flag   <= `DPCS_RST_FLAG;
            cur.overrun_detect_enable <= `DPCS_RST_FLAG;
            cur.scan_chain_debug_port <= 1'h0;
            cur.minimal_port_config   <= 1'h0;
            cur.bus_state             <= DPCS_BUS_IDLE;
            cur.readdata              <= 32'h0000_0000;
        end else if (clk_en_i) begin
            cur <= nxt;
        end
    end

    assign readdata_o              = cur.readdata;
    assign system_power_req_o      = cur.system_power_req;
    assign debug_power_req_o       = cur.debug_power_req;
    assign debug_reset_req_o       = cur.debug_reset_req;
    assign transfer_mode_o         = cur.transfer_mode;
    assign compare_lane_mask_o     = cur.compare_lane_mask;
    assign overrun_detect_enable_o = cur.overrun_detect_enable;

    AST_SYS_REQ_RST: assert property (@(posedge clk_i) $rose(rst_b_i) |-> !system_power_req_o)
        else $error("system power request not zero after reset");
    AST_DBG_REQ_WR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && wr_cs |=> debug_power_req_o == $past(writedata_i[`DPCS_BIT_DBG_REQ]))
        else $error("debug power request did not follow write");
    AST_ACK_SYNC: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i [*3] |-> cs_value[`DPCS_BIT_SYS_ACK] == $past(system_power_ack_i, 2))
        else $error("system ack not two-stage synchronised");
    AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cs_value[25:24] == 2'h0)
        else $error("reserved bits not zero");
    AST_STKERR_SET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && ap_error_i |=> cur.sticky_error_flag)
        else $error("sticky error not set by access-port error");
    AST_WDERR_RO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && wr_cs && !wr_abt && !write_data_error_i && cur.write_data_error_flag
        |=> cur.write_data_error_flag)
        else $error("write data error changed by register write");
    AST_RDOK_TRACK: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && read_done_i |=> cur.read_success_flag == $past(read_ok_i))
        else $error("read success does not track response");
    AST_RDOK_SCAN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cur.scan_chain_debug_port |-> !cs_value[`DPCS_BIT_RDOK])
        else $error("read success visible on scan-chain port");
    AST_ORUN_GATE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && !cur.overrun_detect_enable && !cur.sticky_overrun_flag |=> !cur.sticky_overrun_flag)
        else $error("overrun flagged while detection disabled");
    AST_CMP_MODE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && !cur.sticky_compare_flag && cur.transfer_mode == DPCS_MODE_NORMAL |=> !cur.sticky_compare_flag)
        else $error("compare flag set in normal mode");
    AST_ABT_CLR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && wr_abt && writedata_i[`DPCS_ABT_STKCMP_CLR] && !push_active |=> !cur.sticky_compare_flag)
        else $error("compare flag not cleared by abort");
    AST_WAIT_ONE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && (read_i || write_i) && waitrequest_o ##1 clk_en_i |-> !waitrequest_o)
        else $error("waitrequest held more than one cycle");

    COV_PUSH_CMP: cover property (@(posedge clk_i) push_active && cur.transfer_mode == DPCS_MODE_COMPARE && !lane_match);
    COV_PUSH_VER: cover property (@(posedge clk_i) push_active && cur.transfer_mode == DPCS_MODE_VERIFY && lane_match);
    COV_SET_CLR: cover property (@(posedge clk_i) wr_abt && ap_error_i);
    COV_SCAN_W1C: cover property (@(posedge clk_i) wr_cs && cur.scan_chain_debug_port);
endmodule
`default_nettype wire

// ---- dpcs_params.svh ----
// register offsets, field positions and reset values for the debug port control/status block
`ifndef DPCS_PARAMS_SVH
`define DPCS_PARAMS_SVH
`define DPCS_OFF_CTRL_STAT    4'h4
`define DPCS_OFF_ABORT        4'h0
`define DPCS_OFF_EVENTS       4'h8
`define DPCS_OFF_CONFIG       4'hc
`define DPCS_BIT_SYS_ACK      31
`define DPCS_BIT_SYS_REQ      30
`define DPCS_BIT_DBG_ACK      29
`define DPCS_BIT_DBG_REQ      28
`define DPCS_BIT_RST_ACK      27
`define DPCS_BIT_RST_REQ      26
`define DPCS_CNT_HI           23
`define DPCS_CNT_LO           12
`define DPCS_MASK_HI          11
`define DPCS_MASK_LO          8
`define DPCS_BIT_WDERR        7
`define DPCS_BIT_RDOK         6
`define DPCS_BIT_STKERR       5
`define DPCS_BIT_STKCMP       4
`define DPCS_MODE_HI          3
`define DPCS_MODE_LO          2
`define DPCS_BIT_ORUN         1
`define DPCS_BIT_ORUN_EN      0
`define DPCS_ABT_ORUN_CLR     4
`define DPCS_ABT_WDERR_CLR    3
`define DPCS_ABT_STKERR_CLR   2
`define DPCS_ABT_STKCMP_CLR   1
`define DPCS_EV_WDERR         0
`define DPCS_EV_RD_DONE       1
`define DPCS_EV_RD_OK         2
`define DPCS_EV_AP_ERR        3
`define DPCS_EV_ORUN          4
`define DPCS_EV_PUSH          5
`define DPCS_CFG_SCAN         0
`define DPCS_CFG_MIN          1
`define DPCS_RST_FLAG         1'h0
`endif

// ---- dpcs_pkg.sv ----
// types for the debug port control/status block
package dpcs_pkg;
    typedef enum logic [1:0] {
        DPCS_MODE_NORMAL,
        DPCS_MODE_VERIFY,
        DPCS_MODE_COMPARE,
        DPCS_MODE_RSVD
    } dpcs_mode_e;
    typedef enum logic {
        DPCS_BUS_IDLE,
        DPCS_BUS_DONE
    } dpcs_bus_e;
    typedef struct packed {
        logic [1:0]  sys_ack_sync;
        logic [1:0]  dbg_ack_sync;
        logic [1:0]  rst_ack_sync;
        logic        system_power_req;
        logic        debug_power_req;
        logic        debug_reset_req;
        logic [11:0] transaction_count;
        logic [3:0]  compare_lane_mask;
        logic        write_data_error_flag;
        logic        read_success_flag;
        logic        sticky_error_flag;
        logic        sticky_compare_flag;
        dpcs_mode_e  transfer_mode;
        logic        sticky_overrun_flag;
        logic        overrun_detect_enable;
        logic        scan_chain_debug_port;
        logic        minimal_port_config;
        dpcs_bus_e   bus_state;
        logic [31:0] readdata;
    } dpcs_state_s;
endpackage

// ---- dpcs_pwr_model.sv ----
// power and reset controller model answering request levels with acknowledges
`timescale 1ns/1ps
`default_nettype none
module dpcs_pwr_model #(
    parameter int DELAY = 3
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // requests in, acknowledges out
    input  wire logic [2:0] req_i,
    output logic      [2:0] ack_o
);
    logic [3*DELAY-1:0] sh;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sh <= '0;
        end else begin
            sh <= {sh[3*DELAY-4:0], req_i};
        end
    end
    // ack lags request, like a slow domain settling; never faster than DELAY cycles
    assign ack_o = sh[3*DELAY-1 -: 3];
endmodule
`default_nettype wire

// ---- debug_port_control_status_tb.sv ----
// self-checking bench for the debug port control/status block
`timescale 1ns/1ps
`default_nettype none
`include "dpcs_params.svh"
`define TB_CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module debug_port_control_status_tb;
    import dpcs_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [3:0]  address_i = 4'h0;
    logic        read_i = 1'b0;
    logic        write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0;
    logic [31:0] readdata_o;
    logic        waitrequest_o;
    logic [2:0]  req;
    logic [2:0]  ack;
    logic [5:0]  ev = 6'h0;
    logic        read_ok = 1'b0;
    logic [31:0] pw = 32'h0;
    logic [31:0] pt = 32'h0;
    dpcs_mode_e  transfer_mode_o;
    logic [3:0]  compare_lane_mask_o;
    logic        overrun_detect_enable_o;
    int          errors = 0;
    int          check_count = 0;
    always #12.5 clk_i = ~clk_i;
    dpcs_ctrl_stat i_dpcs_ctrl_stat (.clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
        .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .system_power_ack_i(ack[2]), .debug_power_ack_i(ack[1]), .debug_reset_ack_i(ack[0]),
        .system_power_req_o(req[2]), .debug_power_req_o(req[1]), .debug_reset_req_o(req[0]),
        .write_data_error_i(ev[0]), .read_done_i(ev[1]), .read_ok_i(read_ok), .ap_error_i(ev[2]),
        .overrun_i(ev[3]), .push_valid_i(ev[4]), .transaction_done_i(ev[5]),
        .push_write_data_i(pw), .push_target_data_i(pt), .transfer_mode_o(transfer_mode_o),
        .compare_lane_mask_o(compare_lane_mask_o), .overrun_detect_enable_o(overrun_detect_enable_o));
    dpcs_pwr_model #(.DELAY(3)) i_dpcs_pwr_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .ack_o(ack));
    // one avalon transfer: request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        write_i <= wr;
        read_i <= !wr;
        address_i <= a;
        writedata_i <= d;
        @(posedge clk_i iff waitrequest_o === 1'b0);
        // read data stand at the completing edge
        q = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
        // outputs settle before anyone looks at them
        @(negedge clk_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge clk_i);
        ev <= m;
        @(posedge clk_i);
        ev <= 6'h0;
    endtask
    task automatic t_reset;
        logic [31:0] q;
        rd(`DPCS_OFF_CTRL_STAT, q);
        `TB_CHK(q & 32'hff0000f3, 32'h00000000)
        `TB_CHK(req, 3'b000)
    endtask
    task automatic t_power;
        logic [31:0] q;
        wr(`DPCS_OFF_CTRL_STAT, 32'hff123509);
        `TB_CHK(req, 3'b111)
        `TB_CHK(transfer_mode_o, DPCS_MODE_COMPARE)
        `TB_CHK({compare_lane_mask_o, overrun_detect_enable_o}, 5'h0b)
        // partner lag plus the two-flop synchroniser
        repeat (8) @(posedge clk_i);
        rd(`DPCS_OFF_CTRL_STAT, q);
        `TB_CHK(q, 32'hfc123509)
        wr(`DPCS_OFF_CTRL_STAT, 32'ha8000000);
        repeat (8) @(posedge clk_i);
        rd(`DPCS_OFF_CTRL_STAT, q);
        `TB_CHK(q, 32'h00000000)
    endtask
    task automatic t_flags;
        logic [31:0] q;
        wr(`DPCS_OFF_CTRL_STAT, 32'h00000001);
        read_ok <= 1'b1;
        pulse(6'h0f);
        rd(`DPCS_OFF_CTRL_STAT, q);
        `TB_CHK(q, 32'h000000e3)
        wr(`DPCS_OFF_CTRL_STAT, 32'h000000f3);
        rd(`DPCS_OFF_CTRL_STAT, q);
        `TB_CHK(q, 32'h000000e3)
        wr(`DPCS_OFF_ABORT, 32'h0000001e);
        rd(`DPCS_OFF_CTRL_STAT, q);
        `TB_CHK(q, 32'h00000041)
        read_ok <= 1'b0;
        pulse(6'h02);
        wr(`DPCS_OFF_CTRL_STAT, 32'h00000000);
        pulse(6'h08);
        rd(`DPCS_OFF_CTRL_STAT, q);
        `TB_CHK(q, 32'h00000000)
    endtask
    task automatic t_push(input logic [31:0] cs, input logic [31:0] w, input logic [31:0] t,
                          output logic [31:0] q);
        wr(`DPCS_OFF_ABORT, 32'h00000002);
        wr(`DPCS_OFF_CTRL_STAT, cs);
        pw <= w;
        pt <= t;
        pulse(6'h10);
        rd(`DPCS_OFF_CTRL_STAT, q);
    endtask
    task automatic t_pushed;
        logic [31:0] q;
        t_push(32'h00000108, 32'h11223344, 32'h99223344, q);
        `TB_CHK(q, 32'h00000108)
        t_push(32'h00000108, 32'h11223344, 32'h11223345, q);
        `TB_CHK(q, 32'h00000118)
        wr(`DPCS_OFF_ABORT, 32'h00000002);
        rd(`DPCS_OFF_CTRL_STAT, q);
        `TB_CHK(q, 32'h00000108)
        t_push(32'h00000804, 32'h11000000, 32'h11ffffff, q);
        `TB_CHK(q, 32'h00000814)
        t_push(32'h00000f00, 32'h11000000, 32'h22ffffff, q);
        `TB_CHK(q, 32'h00000f00)
    endtask
    task automatic t_scan;
        logic [31:0] q;
        wr(`DPCS_OFF_CONFIG, 32'h00000001);
        wr(`DPCS_OFF_CTRL_STAT, 32'h00000109);
        pw <= 32'h00000000;
        pt <= 32'h000000ff;
        read_ok <= 1'b1;
        pulse(6'h1f);
        rd(`DPCS_OFF_CTRL_STAT, q);
        `TB_CHK(q, 32'h0000013b)
        wr(`DPCS_OFF_CTRL_STAT, 32'h00000129);
        rd(`DPCS_OFF_CTRL_STAT, q);
        `TB_CHK(q, 32'h0000011b)
        wr(`DPCS_OFF_CTRL_STAT, 32'h00000113);
        rd(`DPCS_OFF_CTRL_STAT, q);
        `TB_CHK(q, 32'h00000101)
        pulse(6'h04);
        wr(`DPCS_OFF_ABORT, 32'h00000004);
        rd(`DPCS_OFF_CTRL_STAT, q);
        `TB_CHK(q, 32'h00000101)
        wr(`DPCS_OFF_CONFIG, 32'h00000000);
        wr(`DPCS_OFF_ABORT, 32'h00000008);
    endtask
    task automatic t_misc;
        logic [31:0] q;
        wr(`DPCS_OFF_CTRL_STAT, 32'h000ff000);
        pulse(6'h20);
        rd(`DPCS_OFF_CTRL_STAT, q);
        `TB_CHK(q, 32'h00100040)
        wr(`DPCS_OFF_CONFIG, 32'h00000002);
        wr(`DPCS_OFF_CTRL_STAT, 32'h00000f0c);
        rd(`DPCS_OFF_CTRL_STAT, q);
        `TB_CHK(q, 32'h00100040)
        wr(`DPCS_OFF_CONFIG, 32'h00000000);
        wr(`DPCS_OFF_EVENTS, 32'hffffffff);
        rd(`DPCS_OFF_EVENTS, q);
        `TB_CHK(q, 32'h00000000)
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_power();
        t_flags();
        t_pushed();
        t_scan();
        t_misc();
        test_done();
    end
    // whole run needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        test_done();
    end
endmodule
`default_nettype wire
